// File: gib_top.sv
// Guest interrupt binding: routes level interrupts to host, guest or background requests.
`timescale 1ns/10ps
`default_nettype none
module gib_top
  import gib_pkg::*;
#(
  parameter int NUM_CH = gib_pkg::GIB_NUM_CH_DEF
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  // Interrupt sources, asynchronous levels
  input  wire logic [NUM_CH-1:0]           eiLevelIn,
  input  wire logic [NUM_CH-1:0]           feLevelIn,
  // Per-input binding
  input  wire gib_pkg::gib_bind_t [NUM_CH-1:0] bindCfg,
  // Core context
  input  wire gib_pkg::gib_ctx_t           coreCtx,
  // Requests to the core
  output logic                             ei_level_host_irq,
  output logic                             fe_level_host_irq,
  output logic                             guest_ei_level_irq,
  output logic                             guest_fe_level_irq,
  output logic                             background_ei_level_irq,
  output logic                             background_fe_level_irq,
  // Vector table selection and channel of highest priority
  output logic                             guestVectorSel,
  output logic [$clog2(NUM_CH+1)-1:0]      eiChannel
);

  logic [NUM_CH-1:0] eiMeta_q;
  logic [NUM_CH-1:0] eiSync_q;
  logic [NUM_CH-1:0] feMeta_q;
  logic [NUM_CH-1:0] feSync_q;
  gib_route_t        eiRoute [NUM_CH];
  gib_route_t        feRoute [NUM_CH];
  gib_req_t          eiReq_d;
  gib_req_t          feReq_d;
  gib_req_t          eiReq_q;
  gib_req_t          feReq_q;
  logic              vecSel_d;
  logic              vecSel_q;
  logic [$clog2(NUM_CH+1)-1:0] eiChan_d;
  logic [$clog2(NUM_CH+1)-1:0] eiChan_q;

  // Two-stage synchronisers; the sources are asynchronous pins.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      eiMeta_q <= '0;
      eiSync_q <= '0;
      feMeta_q <= '0;
      feSync_q <= '0;
    end else begin
      eiMeta_q <= eiLevelIn;
      eiSync_q <= eiMeta_q;
      feMeta_q <= feLevelIn;
      feSync_q <= feMeta_q;
    end
  end

  // Interrupts are levels held by the source, so a held request needs no
  // storage here: it re-evaluates as soon as the context changes.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    gib_route u_ei_route (
      .pending (eiSync_q[i]),
      .bindCfg (bindCfg[i]),
      .ctx     (coreCtx),
      .route   (eiRoute[i])
    );
    gib_route u_fe_route (
      .pending (feSync_q[i]),
      .bindCfg (bindCfg[i]),
      .ctx     (coreCtx),
      .route   (feRoute[i])
    );
  end

  always_comb begin
    eiReq_d  = '0;
    feReq_d  = '0;
    eiChan_d = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      unique case (eiRoute[i])
        GIB_ROUTE_HOST: begin
          eiReq_d.host = 1'b1;
          eiChan_d     = ($clog2(NUM_CH+1))'(i + 1);
        end
        GIB_ROUTE_GUEST: begin
          eiReq_d.guest = 1'b1;
          eiChan_d      = ($clog2(NUM_CH+1))'(i + 1);
        end
        GIB_ROUTE_BACKG: eiReq_d.background = 1'b1;
        GIB_ROUTE_NONE: ;
      endcase
      unique case (feRoute[i])
        GIB_ROUTE_HOST:  feReq_d.host       = 1'b1;
        GIB_ROUTE_GUEST: feReq_d.guest      = 1'b1;
        GIB_ROUTE_BACKG: feReq_d.background = 1'b1;
        GIB_ROUTE_NONE: ;
      endcase
    end
    // Host and guest handlers use separate tables; select by mode.
    vecSel_d = coreCtx.guestMode;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      eiReq_q  <= '0;
      feReq_q  <= '0;
      vecSel_q <= GIB_REQ_RST;
      eiChan_q <= '0;
    end else begin
      eiReq_q  <= eiReq_d;
      feReq_q  <= feReq_d;
      vecSel_q <= vecSel_d;
      eiChan_q <= eiChan_d;
    end
  end

  always_comb begin
    ei_level_host_irq       = eiReq_q.host;
    fe_level_host_irq       = feReq_q.host;
    guest_ei_level_irq      = eiReq_q.guest;
    guest_fe_level_irq      = feReq_q.guest;
    background_ei_level_irq = eiReq_q.background;
    background_fe_level_irq = feReq_q.background;
    guestVectorSel          = vecSel_q;
    eiChannel               = eiChan_q;
  end

  // Helper: OR of guest-bound pending inputs whose ID matches the context.
  logic matchPend;
  logic anyHostPend;
  always_comb begin
    matchPend   = 1'b0;
    anyHostPend = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (eiSync_q[i] && bindCfg[i].toGuest
          && bindCfg[i].guestPartitionId == coreCtx.guestPartitionId) begin
        matchPend = 1'b1;
      end
      if (eiSync_q[i] && !bindCfg[i].toGuest) begin
        anyHostPend = 1'b1;
      end
    end
  end

  property p_guest_match;
    @(posedge mclk) disable iff (!reset_n)
      (coreCtx.guestMode && matchPend) |=> guest_ei_level_irq;
  endproperty
  a_guest_match: assert property (p_guest_match) else $error("guest request missing");

  property p_host_no_guest;
    @(posedge mclk) disable iff (!reset_n)
      !coreCtx.guestMode |=> !guest_ei_level_irq && !background_ei_level_irq;
  endproperty
  a_host_no_guest: assert property (p_host_no_guest) else $error("guest in host mode");

  property p_host_req;
    @(posedge mclk) disable iff (!reset_n)
      anyHostPend |=> ei_level_host_irq;
  endproperty
  a_host_req: assert property (p_host_req) else $error("host request missing");

  property p_bg_forbid;
    @(posedge mclk) disable iff (!reset_n)
      !coreCtx.bgPermit |=> !background_ei_level_irq && !background_fe_level_irq;
  endproperty
  a_bg_forbid: assert property (p_bg_forbid) else $error("background not permitted");

  property p_bg_hold;
    @(posedge mclk) disable iff (!reset_n)
      (background_ei_level_irq && $stable(eiSync_q) && $stable(coreCtx) && $stable(bindCfg))
        |=> background_ei_level_irq;
  endproperty
  a_bg_hold: assert property (p_bg_hold) else $error("background request dropped");

  property p_switch_deliver;
    @(posedge mclk) disable iff (!reset_n)
      ($changed(coreCtx.guestPartitionId) && coreCtx.guestMode && matchPend)
        |=> guest_ei_level_irq;
  endproperty
  a_switch_deliver: assert property (p_switch_deliver) else $error("held not delivered");

  property p_vec_sel;
    @(posedge mclk) disable iff (!reset_n)
      $rose(coreCtx.guestMode) |=> guestVectorSel ##1 (guestVectorSel || !coreCtx.guestMode);
  endproperty
  a_vec_sel: assert property (p_vec_sel) else $error("vector table not switched");

  property p_bind_route;
    @(posedge mclk) disable iff (!reset_n)
      (eiSync_q == '0) |=> !ei_level_host_irq && !guest_ei_level_irq;
  endproperty
  a_bind_route: assert property (p_bind_route) else $error("request without source");

  c_guest: cover property (@(posedge mclk) disable iff (!reset_n) guest_ei_level_irq);
  c_bg: cover property (@(posedge mclk) disable iff (!reset_n)
    background_ei_level_irq ##[1:20] guest_ei_level_irq);
  c_host: cover property (@(posedge mclk) disable iff (!reset_n)
    fe_level_host_irq && coreCtx.guestMode);

endmodule
`default_nettype wire

// File: gib_pkg.sv
// Package with types and constants for the guest interrupt binding block.
package gib_pkg;

  localparam int GIB_NUM_CH_DEF = 8;
  localparam int GIB_GUEST_PARTITION_ID_W     = 3;

  // Reset values of the core-side context and the vector select output.
  localparam logic [GIB_GUEST_PARTITION_ID_W-1:0] GIB_GUEST_PARTITION_ID_RST = 3'h0;
  localparam logic                  GIB_REQ_RST  = 1'h0;

  // Guest-switch settle cycles; unused, the block holds off no guest request after a guest switch.
  localparam int GIB_SWITCH_SETTLE_CYC = 1;

  typedef enum logic [1:0] {
    GIB_ROUTE_NONE  = 2'b00,
    GIB_ROUTE_HOST  = 2'b01,
    GIB_ROUTE_GUEST = 2'b10,
    GIB_ROUTE_BACKG = 2'b11
  } gib_route_t;

  // Binding of one interrupt input.
  typedef struct packed {
    logic                  toGuest;
    logic [GIB_GUEST_PARTITION_ID_W-1:0] guestPartitionId;
  } gib_bind_t;

  // Current execution context of the core.
  typedef struct packed {
    logic                  guestMode;
    logic [GIB_GUEST_PARTITION_ID_W-1:0] guestPartitionId;
    logic                  bgPermit;
  } gib_ctx_t;

  // Request lines toward the core, one set per interrupt class.
  typedef struct packed {
    logic host;
    logic guest;
    logic background;
  } gib_req_t;

endpackage

// File: gib_route.sv
// Routing decision for one interrupt input.
`timescale 1ns/10ps
`default_nettype none
module gib_route
  import gib_pkg::*;
(
  // Interrupt and its binding
  input  wire logic      pending,
  input  wire gib_bind_t bindCfg,
  // Core context
  input  wire gib_ctx_t  ctx,
  // Decision
  output var gib_route_t route
);

  always_comb begin
    route = GIB_ROUTE_NONE;
    if (pending) begin
      if (!bindCfg.toGuest) begin
        route = GIB_ROUTE_HOST;
      end else if (ctx.guestMode) begin
        if (bindCfg.guestPartitionId == ctx.guestPartitionId) begin
          route = GIB_ROUTE_GUEST;
        end else if (ctx.bgPermit) begin
          route = GIB_ROUTE_BACKG;
        end else begin
          route = GIB_ROUTE_NONE;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: gib_core_model.sv
// Core model that holds the running host or guest context seen by the block.
`timescale 1ns/10ps
`default_nettype none
module gib_core_model (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  // Scheduler commands from the bench
  input  wire logic                           runGuest,
  input  wire logic [gib_pkg::GIB_GUEST_PARTITION_ID_W-1:0] runId,
  input  wire logic                           allowBg,
  // Context toward the block
  output var gib_pkg::gib_ctx_t               coreCtx
);
  import gib_pkg::*;

  // The context changes just after a rising edge, as a real core would switch it.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      coreCtx <= '{guestMode: 1'b0, guestPartitionId: GIB_GUEST_PARTITION_ID_RST, bgPermit: 1'b0};
    end else begin
      coreCtx <= '{guestMode: runGuest, guestPartitionId: runId, bgPermit: allowBg};
    end
  end
endmodule
`default_nettype wire

// File: tb_guest_interrupt_binding.sv
// Self-checking bench for the guest interrupt binding block.
`timescale 1ns/10ps
`default_nettype none
module tb_guest_interrupt_binding;
  import gib_pkg::*;
  logic                  mclk     = 1'b0;
  logic                  reset_n  = 1'b0;
  logic [7:0]            eiLevel  = 8'h00;
  logic [7:0]            feLevel  = 8'h00;
  gib_bind_t [7:0]       bindCfg;
  logic                  runGuest = 1'b0;
  logic [GIB_GUEST_PARTITION_ID_W-1:0] runId    = 3'h0;
  logic                  allowBg  = 1'b0;
  gib_ctx_t              coreCtx;
  wire logic [5:0]       reqs;
  logic                  vecSel;
  logic [3:0]            eiChannel;
  int                    errors      = 0;
  int                    check_count = 0;

  always #2.5 mclk = ~mclk;

  // Channel 0 goes to the host; channel i above it to guest i.
  initial begin
    for (int i = 0; i < 8; i++) begin
      bindCfg[i] = '{toGuest: (i != 0), guestPartitionId: i[2:0]};
    end
  end

  gib_core_model u_core (.mclk(mclk), .reset_n(reset_n), .runGuest(runGuest), .runId(runId),
                         .allowBg(allowBg), .coreCtx(coreCtx));

  gib_top #(.NUM_CH(8)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .eiLevelIn(eiLevel), .feLevelIn(feLevel),
    .bindCfg(bindCfg), .coreCtx(coreCtx),
    .ei_level_host_irq(reqs[5]), .fe_level_host_irq(reqs[4]),
    .guest_ei_level_irq(reqs[3]), .guest_fe_level_irq(reqs[2]),
    .background_ei_level_irq(reqs[1]), .background_fe_level_irq(reqs[0]),
    .guestVectorSel(vecSel), .eiChannel(eiChannel));

  // Four edges cover the two sync flops and the output register; the context register loads on the first of them.
  task automatic apply(input logic [7:0] ei, input logic [7:0] fe, input logic g,
                       input logic [2:0] id, input logic p);
    @(negedge mclk);
    eiLevel  = ei;
    feLevel  = fe;
    runGuest = g;
    runId    = id;
    allowBg  = p;
    repeat (4) @(negedge mclk);
  endtask

  task automatic expect_out(input logic [5:0] exp, input logic [3:0] ch, input logic vs);
    check_count++;
    if ({reqs, eiChannel, vecSel} !== {exp, ch, vs}) begin
      errors++;
      $display("wrong value at %0t: req %b ch %0d vsel %b, wanted %b %0d %b", $time, reqs,
               eiChannel, vecSel, exp, ch, vs);
    end
  endtask

  task automatic s_host_mode();
    apply(8'h03, 8'h01, 1'b0, 3'h1, 1'b1);
    expect_out(6'b110000, 4'h1, 1'b0);
    apply(8'h02, 8'h02, 1'b0, 3'h1, 1'b1);
    expect_out(6'b000000, 4'h0, 1'b0);
  endtask

  task automatic s_guest_match();
    apply(8'h04, 8'h04, 1'b1, 3'h2, 1'b0);
    expect_out(6'b001100, 4'h3, 1'b1);
    apply(8'h01, 8'h01, 1'b1, 3'h2, 1'b0);
    expect_out(6'b110000, 4'h1, 1'b1);
  endtask

  task automatic s_background();
    apply(8'h08, 8'h08, 1'b1, 3'h2, 1'b1);
    expect_out(6'b000011, 4'h0, 1'b1);
    apply(8'h08, 8'h08, 1'b1, 3'h3, 1'b1);
    expect_out(6'b001100, 4'h4, 1'b1);
  endtask

  task automatic s_forbidden();
    apply(8'h81, 8'h80, 1'b1, 3'h2, 1'b0);
    expect_out(6'b100000, 4'h1, 1'b1);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    expect_out(6'b000000, 4'h0, 1'b0);
    s_host_mode();
    s_guest_match();
    s_background();
    s_forbidden();
    give_verdict();
  end
endmodule
`default_nettype wire
